// ### logic/sahi_top.sv
// Purpose: Digital host interface of a 16-bit sampling converter.
// Assumes: mclk at 10 MHz; pins are asynchronous and synchronised here.
// Notes: Core results enter through a two-entry buffer.
`timescale 1ns/1ps
module sahi_top (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic chip_select_n,
  input wire logic read_convert,
  input wire logic byte_select,
  input wire logic output_format_select,
  input wire logic ext_clock_select,
  input wire logic serial_bit_clock_in,
  output logic serial_bit_clock_out,
  output logic serial_bit_clock_oe_n,
  output logic serial_result_out,
  input wire logic daisy_chain_in,
  output logic [7:0] parallel_data,
  output logic parallel_data_oe_n,
  output logic busy_n,
  input wire logic analog_power_down,
  input wire logic reference_disable,
  output logic analog_enable,
  output logic internal_reference_enable,
  output logic sample_hold,
  input wire logic core_valid,
  output logic core_ready,
  input wire logic [15:0] core_result
);
  typedef enum logic [1:0] {SAHI_IDLE, SAHI_CONV, SAHI_FINISH} sahi_state_e;

  logic cs_n_s, rc_s, byte_s, fmt_s, ext_s, sclk_s, tag_s, pd_s, reference_disable_s;
  sahi_sync #(.RST_VAL(1'b1)) u_cs (.clk(mclk), .rst(sys_rst), .d(chip_select_n), .q(cs_n_s));
  sahi_sync #(.RST_VAL(1'b1)) u_rc (.clk(mclk), .rst(sys_rst), .d(read_convert), .q(rc_s));
  sahi_sync u_by (.clk(mclk), .rst(sys_rst), .d(byte_select), .q(byte_s));
  sahi_sync u_fm (.clk(mclk), .rst(sys_rst), .d(output_format_select), .q(fmt_s));
  sahi_sync u_ex (.clk(mclk), .rst(sys_rst), .d(ext_clock_select), .q(ext_s));
  sahi_sync u_sk (.clk(mclk), .rst(sys_rst), .d(serial_bit_clock_in), .q(sclk_s));
  sahi_sync u_tg (.clk(mclk), .rst(sys_rst), .d(daisy_chain_in), .q(tag_s));
  sahi_sync u_pd (.clk(mclk), .rst(sys_rst), .d(analog_power_down), .q(pd_s));
  sahi_sync u_rf (.clk(mclk), .rst(sys_rst), .d(reference_disable), .q(reference_disable_s));

  // Core results pass a two-entry buffer; it drains only at conversion end.
  logic buf_valid, buf_ready;
  logic [15:0] buf_data;
  sahi_buf2 #(.W(sahi_pkg::RESULT_W)) u_buf (
    .clk(mclk),
    .rst(sys_rst),
    .in_valid(core_valid),
    .in_ready(core_ready),
    .in_data(core_result),
    .out_valid(buf_valid),
    .out_ready(buf_ready),
    .out_data(buf_data)
  );

  logic start_n_r, start_n_nxt, sclk_d_r, sclk_d_nxt;
  logic start_fall, sclk_fall;
  logic rd_en_r, rd_en_nxt;
  sahi_state_e st_r, st_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic [15:0] result_r, result_nxt;
  logic [15:0] shift_r, shift_nxt;
  logic [4:0] bits_r, bits_nxt;
  logic [15:0] half_r, half_nxt;
  logic sclk_r, sclk_nxt, sdo_r, sdo_nxt;
  logic [7:0] pdata_r, pdata_nxt;
  logic [15:0] fmt_result;
  logic int_sending;

  assign start_fall = start_n_r && !start_n_nxt;
  assign sclk_fall = sclk_d_r && !sclk_s;
  assign int_sending = !ext_s && (bits_r != 5'h0);
  // Core output is offset binary; inverting the MSB gives two's complement.
  assign fmt_result = fmt_s ? result_r : {~result_r[15], result_r[14:0]};

  always_comb begin
    start_n_nxt = cs_n_s || rc_s;
    sclk_d_nxt = sclk_s;
    rd_en_nxt = rd_en_r;
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    result_nxt = result_r;
    buf_ready = 1'b0;
    // Select falling with read high enables the bus just as a read rise does.
    if (!cs_n_s && rc_s) begin
      rd_en_nxt = 1'b1;
    end
    if (cs_n_s || !rc_s) begin
      rd_en_nxt = 1'b0;
    end
    unique case (st_r)
      SAHI_IDLE: begin
        if (start_fall) begin
          st_nxt = SAHI_CONV;
          cnt_nxt = 16'(sahi_pkg::CONV_CYCLES - 1);
        end
      end
      SAHI_CONV: begin
        // Requests here are not looked at at all.
        if (cnt_r != 16'h0000) begin
          cnt_nxt = cnt_r - 16'h0001;
        end else begin
          st_nxt = SAHI_FINISH;
        end
      end
      SAHI_FINISH: begin
        // Waits for a core word and for the internal shift to finish.
        if (buf_valid && !int_sending) begin
          buf_ready = 1'b1;
          result_nxt = buf_data;
          st_nxt = SAHI_IDLE;
        end
      end
    endcase
  end

  always_comb begin
    shift_nxt = shift_r;
    bits_nxt = bits_r;
    half_nxt = half_r;
    sclk_nxt = sclk_r;
    sdo_nxt = sdo_r;
    if (!ext_s) begin
      sclk_nxt = 1'b0;
      if (st_r == SAHI_IDLE && start_fall) begin
        shift_nxt = fmt_result;
        bits_nxt = 5'(sahi_pkg::SER_BITS);
        half_nxt = 16'(sahi_pkg::SCLK_HALF_CYCLES - 1);
        sdo_nxt = fmt_result[15];
      end else if (bits_r != 5'h0) begin
        sclk_nxt = sclk_r;
        if (half_r != 16'h0000) begin
          half_nxt = half_r - 16'h0001;
        end else begin
          half_nxt = 16'(sahi_pkg::SCLK_HALF_CYCLES - 1);
          sclk_nxt = ~sclk_r;
          if (sclk_r) begin
            // Falling edge of the generated clock advances the bit.
            bits_nxt = bits_r - 5'h01;
            shift_nxt = {shift_r[14:0], 1'b0};
            sdo_nxt = shift_r[14];
          end
        end
      end
    end else begin
      bits_nxt = 5'h0;
      sclk_nxt = 1'b0;
      if (rd_en_nxt && !rd_en_r) begin
        shift_nxt = fmt_result;
        sdo_nxt = fmt_result[15];
      end else if (sclk_fall) begin
        // Daisy-chain input fills behind the outgoing result.
        shift_nxt = {shift_r[14:0], tag_s};
        sdo_nxt = shift_r[14];
      end
    end
  end

  always_comb begin
    pdata_nxt = byte_s ? fmt_result[sahi_pkg::LB_MSB -: 8]
                       : fmt_result[sahi_pkg::SB_MSB -: 8];
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      start_n_r <= 1'b1;
      sclk_d_r <= 1'b0;
      rd_en_r <= 1'b0;
      st_r <= SAHI_IDLE;
      cnt_r <= 16'h0000;
      result_r <= sahi_pkg::RESULT_RST;
      shift_r <= 16'h0000;
      bits_r <= 5'h00;
      half_r <= 16'h0000;
      sclk_r <= 1'b0;
      sdo_r <= 1'b0;
      pdata_r <= 8'h00;
    end else begin
      start_n_r <= start_n_nxt;
      sclk_d_r <= sclk_d_nxt;
      rd_en_r <= rd_en_nxt;
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      result_r <= result_nxt;
      shift_r <= shift_nxt;
      bits_r <= bits_nxt;
      half_r <= half_nxt;
      sclk_r <= sclk_nxt;
      sdo_r <= sdo_nxt;
      pdata_r <= pdata_nxt;
    end
  end

  assign busy_n = (st_r == SAHI_IDLE);
  assign sample_hold = (st_r != SAHI_IDLE);
  assign parallel_data = pdata_r;
  assign parallel_data_oe_n = !rd_en_r;
  assign serial_bit_clock_out = sclk_r;
  assign serial_bit_clock_oe_n = ext_s;
  assign serial_result_out = sdo_r;
  assign analog_enable = !pd_s;
  assign internal_reference_enable = !reference_disable_s;
endmodule // sahi_top

// ### common/sahi_pkg.sv
// Purpose: Shared constants for the converter host interface.
// Assumes: System clock mclk at 10 MHz.
// Notes: Times are in ns; cycle counts derive from the clock period.
package sahi_pkg;
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned RESULT_W = 16;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned SER_BITS = 16;
  // Conversion time of the modelled successive-approximation core.
  localparam int unsigned CONV_TIME_NS = 20000;
  localparam int unsigned CONV_CYCLES = CONV_TIME_NS / CLK_PERIOD_NS;
  // Half period of the internally generated serial bit clock.
  localparam int unsigned SCLK_HALF_NS = 400;
  localparam int unsigned SCLK_HALF_CYCLES =
    (SCLK_HALF_NS / CLK_PERIOD_NS) > 0 ? SCLK_HALF_NS / CLK_PERIOD_NS : 1;
  localparam logic [15:0] RESULT_RST = 16'h0000;
  localparam int unsigned SB_MSB = 15;
  localparam int unsigned LB_MSB = 7;
endpackage

// ### logic/sahi_sync.sv
// Purpose: Two flip-flop synchroniser for one level.
// Assumes: Input is asynchronous to clk.
// Notes: The first stage is read only by the second.
`timescale 1ns/1ps
module sahi_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic d,
  output logic q
);
  logic meta_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      // Resetting to the idle level of the pin avoids a false edge after reset.
      meta_r <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule // sahi_sync

// ### logic/sahi_buf2.sv
// Purpose: Two-entry buffer with valid and ready on both sides.
// Assumes: One clock.
// Notes: Full and empty are exact.
`timescale 1ns/1ps
module sahi_buf2 #(
  parameter int unsigned W = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  logic [W-1:0] mem_r [2];
  logic [W-1:0] mem_nxt [2];
  logic rd_r, rd_nxt, wr_r, wr_nxt;
  logic [1:0] cnt_r, cnt_nxt;
  logic push, pop;
  assign in_ready = (cnt_r != 2'h2);
  assign out_valid = (cnt_r != 2'h0);
  assign out_data = mem_r[rd_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always_comb begin
    mem_nxt = mem_r;
    rd_nxt = rd_r;
    wr_nxt = wr_r;
    cnt_nxt = cnt_r;
    if (push) begin
      mem_nxt[wr_r] = in_data;
      wr_nxt = ~wr_r;
    end
    if (pop) begin
      rd_nxt = ~rd_r;
    end
    if (push && !pop) begin
      cnt_nxt = cnt_r + 2'h1;
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - 2'h1;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mem_r[0] <= '0;
      mem_r[1] <= '0;
      rd_r <= 1'b0;
      wr_r <= 1'b0;
      cnt_r <= 2'h0;
    end else begin
      mem_r <= mem_nxt;
      rd_r <= rd_nxt;
      wr_r <= wr_nxt;
      cnt_r <= cnt_nxt;
    end
  end
endmodule // sahi_buf2

// ### verification/sahi_top_sva.sv
// Purpose: Port-level checks for the converter host interface.
// Assumes: Single mclk domain, sys_rst asynchronous and active high.
// Notes: Pin inputs pass two synchroniser flops before they act.
`timescale 1ns/1ps
module sahi_top_sva (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic chip_select_n,
  input wire logic read_convert,
  input wire logic ext_clock_select,
  input wire logic serial_bit_clock_out,
  input wire logic serial_bit_clock_oe_n,
  input wire logic parallel_data_oe_n,
  input wire logic busy_n,
  input wire logic analog_power_down,
  input wire logic reference_disable,
  input wire logic analog_enable,
  input wire logic internal_reference_enable
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  int unsigned low_r;
  int unsigned low_nxt;
  // Counts how long busy has been low.
  always_comb low_nxt = busy_n ? 0 : low_r + 1;
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) low_r <= 0;
    else low_r <= low_nxt;
  end
  AST_HIZ_CS: assert property (chip_select_n [*4] |-> parallel_data_oe_n)
    else $error("data bus driven with select high");
  AST_HIZ_RC: assert property (!read_convert [*4] |-> parallel_data_oe_n)
    else $error("data bus driven with convert low");
  AST_START: assert property (busy_n && !chip_select_n && $fell(read_convert)
    |-> ##[3:5] !busy_n) else $error("convert edge did not start");
  AST_START_CS: assert property (busy_n && !read_convert && $fell(chip_select_n)
    |-> ##[3:5] !busy_n) else $error("select edge did not start");
  AST_HOLD: assert property ($fell(busy_n) |=> !busy_n [*8])
    else $error("busy released early");
  AST_MIN: assert property ($rose(busy_n) |-> low_r >= sahi_pkg::CONV_CYCLES)
    else $error("busy shorter than conversion");
  AST_MAX: assert property ($rose(busy_n) |-> low_r <= 400)
    else $error("busy stretched by a request");
  AST_CLK_DIR: assert property (ext_clock_select [*3] |-> serial_bit_clock_oe_n)
    else $error("bit clock driven in external mode");
  AST_CLK_QUIET: assert property (ext_clock_select [*4] |-> !serial_bit_clock_out)
    else $error("bit clock toggles in external mode");
  AST_PWR: assert property (analog_power_down [*3] |-> !analog_enable)
    else $error("analog left on");
  AST_REF: assert property (reference_disable [*3] |-> !internal_reference_enable)
    else $error("reference left on");
  cover property ($fell(busy_n));
  cover property ($rose(busy_n));
  cover property ($fell(parallel_data_oe_n));
endmodule // sahi_top_sva
bind sahi_top sahi_top_sva chk (.mclk(mclk), .sys_rst(sys_rst),
  .chip_select_n(chip_select_n), .read_convert(read_convert),
  .ext_clock_select(ext_clock_select), .serial_bit_clock_out(serial_bit_clock_out),
  .serial_bit_clock_oe_n(serial_bit_clock_oe_n), .parallel_data_oe_n(parallel_data_oe_n),
  .busy_n(busy_n), .analog_power_down(analog_power_down),
  .reference_disable(reference_disable), .analog_enable(analog_enable),
  .internal_reference_enable(internal_reference_enable));

// ### verification/sahi_host_clk.sv
// Purpose: Host side source of the external bit clock.
// Assumes: Bit clock period 800 ns.
// Notes: Clock idles low between frames; daisy line toggles each bit.
`timescale 1ns/1ps
module sahi_host_clk (
  input wire logic go,
  output logic serial_bit_clock_in,
  output logic daisy_chain_in
);
  initial begin
    serial_bit_clock_in = 1'b0;
    daisy_chain_in = 1'b0;
  end
  always @(posedge go) begin
    repeat (16) begin
      #400 serial_bit_clock_in = 1'b1;
      #400 serial_bit_clock_in = 1'b0;
      daisy_chain_in = ~daisy_chain_in;
    end
  end
endmodule // sahi_host_clk

// ### verification/sahi_top_bench.sv
// Purpose: Self-checking bench for the converter host interface.
// Assumes: Inputs change on the falling edge of mclk.
// Notes: Each conversion takes its word from the core buffer.
`timescale 1ns/1ps
`define CHK(a, b, m) begin n_checks++; if ((a) !== (b)) begin error_cnt++; \
  $display("MISMATCH t=%0t %s", $time, m); end end
module sahi_top_bench;
  logic mclk = 0, sys_rst = 1, chip_select_n = 1, read_convert = 1, byte_select = 0;
  logic output_format_select = 1, ext_clock_select = 0, analog_power_down = 0;
  logic reference_disable = 0, core_valid = 0, go = 0;
  logic [15:0] core_result = 16'h0000, cap = 16'h0000, last = sahi_pkg::RESULT_RST;
  logic serial_bit_clock_in, serial_bit_clock_out, serial_bit_clock_oe_n, serial_result_out;
  logic daisy_chain_in, parallel_data_oe_n, busy_n, analog_enable, internal_reference_enable;
  logic sample_hold, core_ready;
  logic [7:0] parallel_data;
  int error_cnt = 0, n_checks = 0, nbits = 0;
  always #50 mclk = ~mclk;
  sahi_top uut (.mclk(mclk), .sys_rst(sys_rst), .chip_select_n(chip_select_n),
    .read_convert(read_convert), .byte_select(byte_select),
    .output_format_select(output_format_select), .ext_clock_select(ext_clock_select),
    .serial_bit_clock_in(serial_bit_clock_in), .serial_bit_clock_out(serial_bit_clock_out),
    .serial_bit_clock_oe_n(serial_bit_clock_oe_n), .serial_result_out(serial_result_out),
    .daisy_chain_in(daisy_chain_in), .parallel_data(parallel_data),
    .parallel_data_oe_n(parallel_data_oe_n), .busy_n(busy_n),
    .analog_power_down(analog_power_down), .reference_disable(reference_disable),
    .analog_enable(analog_enable), .internal_reference_enable(internal_reference_enable),
    .sample_hold(sample_hold), .core_valid(core_valid), .core_ready(core_ready),
    .core_result(core_result));
  sahi_host_clk host (.go(go), .serial_bit_clock_in(serial_bit_clock_in),
    .daisy_chain_in(daisy_chain_in));
  wire sck = ext_clock_select ? serial_bit_clock_in : serial_bit_clock_out;
  always @(posedge sck) begin
    cap = {cap[14:0], serial_result_out};
    nbits++;
  end
  function automatic logic [15:0] fmt(input logic [15:0] w);
    return output_format_select ? w : w ^ 16'h8000;
  endfunction
  task cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task wait_busy(input logic v);
    for (int i = 0; i < 1000 && busy_n !== v; i++) @(negedge mclk);
    `CHK(busy_n, v, "busy wait")
  endtask
  task push(input logic [15:0] w);
    core_result = w;
    core_valid = 1'b1;
    while (core_ready !== 1'b1) @(negedge mclk);
    @(posedge mclk);
    @(negedge mclk);
    core_valid = 1'b0;
    cyc(1);
  endtask
  task conv(input logic [15:0] w, input bit by_cs, input bit again);
    logic [15:0] e;
    e = fmt(last);
    nbits = 0;
    if (by_cs) read_convert = 1'b0;
    else chip_select_n = 1'b0;
    cyc(2);
    if (by_cs) chip_select_n = 1'b0;
    else read_convert = 1'b0;
    cyc(4);
    read_convert = 1'b1;
    wait_busy(1'b0);
    `CHK(sample_hold, 1'b1, "hold during conversion")
    cyc(8);
    `CHK(parallel_data_oe_n, 1'b0, "read enable")
    `CHK(parallel_data, e[15:8], "old result")
    if (again) begin
      read_convert = 1'b0;
      cyc(2);
      read_convert = 1'b1;
    end
    wait_busy(1'b1);
    `CHK(nbits, ext_clock_select ? 0 : 16, "bit count")
    if (!ext_clock_select) `CHK(cap, e, "serial word")
    last = w;
    e = fmt(w);
    cyc(8);
    `CHK(parallel_data, e[15:8], "high byte")
    byte_select = 1'b1;
    cyc(8);
    `CHK(parallel_data, e[7:0], "low byte")
    byte_select = 1'b0;
    chip_select_n = 1'b1;
    cyc(5);
    `CHK(parallel_data_oe_n, 1'b1, "bus float")
  endtask
  task t_buf;
    push(16'h8421);
    push(16'h7FFE);
    core_result = 16'hC3C3;
    core_valid = 1'b1;
    cyc(3);
    `CHK(core_ready, 1'b0, "buffer full")
    core_valid = 1'b0;
    conv(16'h8421, 0, 1);
    output_format_select = 1'b0;
    conv(16'h7FFE, 1, 0);
    output_format_select = 1'b1;
    $display("test buffer done");
  endtask
  task t_power;
    analog_power_down = 1'b1;
    reference_disable = 1'b1;
    cyc(4);
    `CHK(analog_enable, 1'b0, "power down")
    `CHK(internal_reference_enable, 1'b0, "ref off")
    push(16'h0001);
    conv(16'h0001, 1, 0);
    analog_power_down = 1'b0;
    reference_disable = 1'b0;
    cyc(4);
    `CHK(analog_enable, 1'b1, "power up")
    `CHK(internal_reference_enable, 1'b1, "ref on")
    $display("test power done");
  endtask
  task t_ext;
    ext_clock_select = 1'b1;
    push(16'h5A3C);
    conv(16'h5A3C, 0, 0);
    nbits = 0;
    chip_select_n = 1'b0;
    cyc(8);
    go = 1'b1;
    cyc(140);
    go = 1'b0;
    `CHK(nbits, 16, "ext bits")
    `CHK(cap, fmt(last), "ext word")
    chip_select_n = 1'b1;
    ext_clock_select = 1'b0;
    $display("test external clock done");
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #3000000;
    error_cnt++;
    finish_test;
  end
  initial begin
    cyc(6);
    sys_rst = 1'b0;
    cyc(3);
    `CHK(busy_n, 1'b1, "reset busy")
    `CHK(core_ready, 1'b1, "reset buffer")
    $display("test reset done");
    t_buf;
    t_power;
    t_ext;
    finish_test;
  end
endmodule // sahi_top_bench
